// ---- include/cbs_pkg.sv ----
// Constants and field layout of the cell-balance sequencer control block
package cbs_pkg;
  // ----------------------------------------------------------------
  // Clock and time
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;            // 20 MHz system clock
  localparam int unsigned SEC_NS        = 1_000_000_000; // One second in ns
  localparam int unsigned CYC_PER_SEC   = SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned SEC_PER_MIN   = 60;            // Minute unit in seconds
  localparam int unsigned SEC_PER_HOUR  = 3600;          // Hour unit in seconds

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_UV_SEL = 10'h07e; // balance_uv_threshold_select
  localparam logic [9:0] IDX_DELAY  = 10'h07f; // balance_delay_control
  localparam logic [9:0] IDX_CTRL   = 10'h080; // balance_control
  localparam logic [9:0] IDX_STATUS = 10'h088; // Sequencer status

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int THR_LSB  = 2;   // balance_uv_threshold 15:2
  localparam int SRC_BIT  = 0;   // threshold_from_lowest_cell
  localparam int NTF_LSB  = 8;   // progress_notice_interval 9:8
  localparam int CAL_LSB  = 0;   // calibration_substitution_rate 2:0
  localparam int ACT_LSB  = 14;  // balance_activity_state 15:14
  localparam int MODE_LSB = 11;  // balance_mode 13:11
  localparam int IIR_BIT  = 10;  // filter_restart_request
  localparam int HOLD_LSB = 8;   // shutdown_hold_select 9:8
  localparam int DUTY_LSB = 4;   // balance_duty_cycle 7:4
  localparam int DONE_BIT = 3;   // completion_alert_enable
  localparam int TEMP_BIT = 2;   // thermal_exit_enable
  localparam int MEAS_LSB = 0;   // embedded_measure_select 1:0
  localparam int UVS_BIT  = 13;  // Status: undervoltage suspend seen

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [13:0] THR_RST     = 14'h3fff; // Blocks balancing until set
  localparam logic [2:0]  MODE_OFF    = 3'h0;
  localparam logic [2:0]  MODE_DISCH  = 3'h1;     // Emergency discharge by hour
  localparam logic [1:0]  ACT_OFF     = 2'h0;
  localparam logic [1:0]  ACT_RUN     = 2'h1;
  localparam logic [1:0]  ACT_DONE    = 2'h2;
  localparam logic [1:0]  ACT_HALT    = 2'h3;
  localparam logic [1:0]  MEAS_CHECK  = 2'h3;     // Measure and check threshold
endpackage : cbs_pkg

// ---- include/cbs_sup_if.sv ----
// Link between the control core and the supervisory scheduler
`timescale 1ns/1ns
`default_nettype none
interface cbs_sup_if;
  logic       pair_done; // Even and odd period pair finished
  logic       meas_en;   // Embedded measurements enabled
  logic [2:0] cal_rate;  // Calibration substitution code
  logic       restart;   // New mode launched
  logic       adc_req;   // Supervisory ADC measurement request
  logic       cal_req;   // Calibration in place of a measurement
  modport ctrl  (output pair_done, meas_en, cal_rate, restart, input adc_req, cal_req);
  modport sched (input pair_done, meas_en, cal_rate, restart, output adc_req, cal_req);
endinterface : cbs_sup_if
`default_nettype wire

// ---- design/cbs_sec_div.sv ----
// One-second tick divider
`timescale 1ns/1ns
`default_nettype none
module cbs_sec_div #(
  parameter int unsigned CYCLES = cbs_pkg::CYC_PER_SEC // Clock cycles per second
) (
  input  wire logic clk,      // System clock
  input  wire logic rst_n,    // Async reset, active low
  output logic      sec_tick  // One-cycle pulse each second
);
  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  logic [W-1:0] cnt_r; // Cycles into the current second

  // ----------------------------------------------------------------
  // Free-running divider; real time, never scaled by duty cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r    <= '0;
      sec_tick <= 1'b0;
    end else if (cnt_r == W'(CYCLES - 1)) begin
      cnt_r    <= '0;
      sec_tick <= 1'b1;
    end else begin
      cnt_r    <= cnt_r + 1'b1;
      sec_tick <= 1'b0;
    end
  end
endmodule : cbs_sec_div
`default_nettype wire

// ---- design/cbs_sup_sched.sv ----
// Supervisory measurement / calibration scheduler
`timescale 1ns/1ns
`default_nettype none
module cbs_sup_sched (
  input wire logic clk,   // System clock
  input wire logic rst_n, // Async reset, active low
  cbs_sup_if.sched sup    // Requests from and to the control core
);
  logic [4:0] cnt_r; // Supervisory cycles since last calibration

  // Cycles between calibrations; zero means never, reserved 101 included
  function automatic logic [5:0] cal_period(input logic [2:0] code);
    case (code)
      3'h1:    cal_period = 6'h02;
      3'h2:    cal_period = 6'h04;
      3'h3:    cal_period = 6'h08;
      3'h4:    cal_period = 6'h0c;
      3'h6:    cal_period = 6'h18;
      3'h7:    cal_period = 6'h20;
      default: cal_period = 6'h00;
    endcase
  endfunction : cal_period

  // ----------------------------------------------------------------
  // One request per period pair, calibration substituted on schedule
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r       <= '0;
      sup.adc_req <= 1'b0;
      sup.cal_req <= 1'b0;
    end else begin
      sup.adc_req <= 1'b0;
      sup.cal_req <= 1'b0;
      if (sup.restart) begin
        cnt_r <= '0;
      end else if (sup.pair_done && sup.meas_en) begin
        if (cal_period(sup.cal_rate) == 6'h00) begin
          sup.adc_req <= 1'b1;
        end else if ({1'b0, cnt_r} == cal_period(sup.cal_rate) - 6'h01) begin
          sup.cal_req <= 1'b1;
          cnt_r       <= '0;
        end else begin
          sup.adc_req <= 1'b1;
          cnt_r       <= cnt_r + 5'h01;
        end
      end
    end
  end
endmodule : cbs_sup_sched
`default_nettype wire

// ---- design/cbs_ctrl.sv ----
// Cell-balance sequencer control registers, timers and supervision
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - 14-bit threshold suspends low cells
// - Threshold resets to all ones
// - Source clear: written field becomes threshold
// - Source set: lowest cell result loaded
// - Source set with polarity one: all ones
// - Delay writes ignored in discharge/automated
// - Notice field: none, 1, 2, 4 hours
// - Notice counted in real seconds
// - Notices continue during shutdown hold
// - One supervisory measurement per period pair
// - Calibration replaces measurement at selected rate
// - Measurements off: calibration rate ignored
// - Nonzero mode write restarts timer, launches
// - Activity: off, active, normal completion
// - Activity 11 on unexpected halt
// - Mode decode: discharge, manual, automated units
// - Measure select: off, measure, measure+check
// - Lowest-cell write during scan rejected
module cbs_ctrl #(
  parameter int unsigned CYC_PER_SEC = cbs_pkg::CYC_PER_SEC, // Cycles per second
  parameter int          CELLS       = 14                    // Cell channels
) (
  input  wire logic                clk,                     // System clock
  input  wire logic                rst_n,                   // Async reset, active low
  input  wire logic                psel,                    // APB select
  input  wire logic                penable,                 // APB access phase
  input  wire logic                pwrite,                  // APB write
  input  wire logic [11:0]         paddr,                   // APB byte address
  input  wire logic [31:0]         pwdata,                  // APB write data
  output logic      [31:0]         prdata,                  // APB read data
  output logic                     pready,                  // APB ready
  output logic                     pslverr,                 // APB error, unmapped
  input  wire logic [CELLS*14-1:0] cell_voltage_result,     // Cell results, cell 0 low
  input  wire logic [3:0]          lowest_cell_index,       // Index of lowest cell
  input  wire logic                extreme_search_polarity, // Min/max polarity select
  input  wire logic                scan_active,             // Measurement scan running
  input  wire logic                pair_done,               // Period pair finished
  input  wire logic                sup_result_valid,        // Supervisory result strobe
  input  wire logic [13:0]         sup_result,              // Supervisory result
  input  wire logic                hold_active,             // Shutdown hold keeps power
  input  wire logic                exit_normal,             // Threshold/expiry exit
  input  wire logic                exit_thermal,            // Thermal exit
  input  wire logic                exit_timeout,            // Timeout exit
  input  wire logic                exit_cal_fault,          // Calibration fault exit
  output logic      [2:0]          balance_mode,            // Active mode
  output logic                     launch_pulse,            // Mode launched
  output logic                     adc_request,             // Supervisory measurement
  output logic                     cal_request,             // Substituted calibration
  output logic                     uv_suspend,              // Cell below threshold
  output logic                     progress_notice_alert,   // Progress notice pulse
  output logic                     write_rejected_alert,    // Rejected write pulse
  output logic                     filter_restart_request,  // Filter restart bit
  output logic      [1:0]          shutdown_hold_select,    // Hold mode
  output logic      [3:0]          balance_duty_cycle,      // Duty cycle
  output logic                     completion_alert_enable, // Done alert enable
  output logic                     thermal_exit_enable      // Thermal exit enable
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [13:0] thr_r;     // balance_uv_threshold
  logic        src_r;     // threshold_from_lowest_cell
  logic [1:0]  ntf_r;     // progress_notice_interval
  logic [2:0]  cal_r;     // calibration_substitution_rate
  logic [1:0]  meas_r;    // embedded_measure_select
  logic [1:0]  act_r;     // balance_activity_state
  logic [9:0]  timer_r;   // balance_elapsed_timer
  logic [11:0] unit_r;    // Seconds into current timer unit
  logic [13:0] ntf_cnt_r; // Seconds into current notice interval
  logic        sec_tick;  // One-second enable

  cbs_sup_if sup ();

  // Register index hit on an aligned word address
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a[11:2] == idx) && (a[1:0] == 2'h0);
  endfunction : hit

  // Seconds per timer unit for a mode
  function automatic logic [11:0] unit_secs(input logic [2:0] m);
    if (m == cbs_pkg::MODE_DISCH) unit_secs = 12'(cbs_pkg::SEC_PER_HOUR);
    else if (m[0])                unit_secs = 12'(cbs_pkg::SEC_PER_MIN);
    else                          unit_secs = 12'h001;
  endfunction : unit_secs

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_fire;  // Write completes this edge
  logic wr_uv;    // Threshold select written
  logic wr_dly;   // Delay control written
  logic wr_ctrl;  // Balance control written
  logic auto_md;  // Automated mode 1xx
  logic run_md;   // Discharge or automated mode
  logic launch;   // Nonzero mode written
  logic reject;   // Lowest-cell load during scan
  logic [13:0] picked;

  assign wr_fire = psel && penable && pwrite && pready;
  assign wr_uv   = wr_fire && hit(paddr, cbs_pkg::IDX_UV_SEL);
  assign wr_dly  = wr_fire && hit(paddr, cbs_pkg::IDX_DELAY);
  assign wr_ctrl = wr_fire && hit(paddr, cbs_pkg::IDX_CTRL);
  assign auto_md = balance_mode[2];
  assign run_md  = auto_md || (balance_mode == cbs_pkg::MODE_DISCH);
  assign launch  = wr_ctrl && (pwdata[cbs_pkg::MODE_LSB +: 3] != cbs_pkg::MODE_OFF);
  assign reject  = wr_uv && !auto_md && pwdata[cbs_pkg::SRC_BIT] && scan_active;
  // Out-of-range index reads as all ones, which can never release a cell
  assign picked  = (int'(lowest_cell_index) < CELLS) ?
                   cell_voltage_result[lowest_cell_index*14 +: 14] : cbs_pkg::THR_RST;

  // ----------------------------------------------------------------
  // APB slave: one wait state so read data leaves a flip-flop
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= 1'b1;
      prdata  <= '0;
      if (hit(paddr, cbs_pkg::IDX_UV_SEL)) begin
        pslverr <= 1'b0;
        prdata  <= {16'h0, thr_r, 1'b0, src_r};
      end else if (hit(paddr, cbs_pkg::IDX_DELAY)) begin
        pslverr <= 1'b0;
        prdata  <= {22'h0, ntf_r, 5'h0, cal_r};
      end else if (hit(paddr, cbs_pkg::IDX_CTRL)) begin
        pslverr <= 1'b0;
        prdata  <= {16'h0, act_r, balance_mode, filter_restart_request,
                    shutdown_hold_select, balance_duty_cycle,
                    completion_alert_enable, thermal_exit_enable, meas_r};
      end else if (hit(paddr, cbs_pkg::IDX_STATUS)) begin
        pslverr <= 1'b0;
        prdata  <= {16'h0, act_r, uv_suspend, 3'h0, timer_r};
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Undervoltage threshold; locked while an automated mode is selected
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_r <= cbs_pkg::THR_RST;
      src_r <= 1'b0;
    end else if (wr_uv && !auto_md && !reject) begin
      src_r <= pwdata[cbs_pkg::SRC_BIT];
      if (!pwdata[cbs_pkg::SRC_BIT])
        thr_r <= pwdata[cbs_pkg::THR_LSB +: 14];
      else if (extreme_search_polarity)
        thr_r <= cbs_pkg::THR_RST;
      else
        thr_r <= picked;
    end
  end

  // Rejection is only reported, the stored threshold is untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) write_rejected_alert <= 1'b0;
    else        write_rejected_alert <= reject;
  end

  // ----------------------------------------------------------------
  // Delay control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ntf_r <= 2'h0;
      cal_r <= 3'h0;
    end else if (wr_dly && !run_md) begin
      ntf_r <= pwdata[cbs_pkg::NTF_LSB +: 2];
      cal_r <= pwdata[cbs_pkg::CAL_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Balance control fields
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      balance_mode            <= cbs_pkg::MODE_OFF;
      filter_restart_request  <= 1'b0;
      shutdown_hold_select    <= 2'h0;
      balance_duty_cycle      <= 4'h0;
      completion_alert_enable <= 1'b0;
      thermal_exit_enable     <= 1'b0;
      meas_r                  <= 2'h0;
      launch_pulse            <= 1'b0;
    end else begin
      launch_pulse <= launch;
      if (wr_ctrl) begin
        balance_mode            <= pwdata[cbs_pkg::MODE_LSB +: 3];
        filter_restart_request  <= pwdata[cbs_pkg::IIR_BIT];
        shutdown_hold_select    <= pwdata[cbs_pkg::HOLD_LSB +: 2];
        balance_duty_cycle      <= pwdata[cbs_pkg::DUTY_LSB +: 4];
        completion_alert_enable <= pwdata[cbs_pkg::DONE_BIT];
        thermal_exit_enable     <= pwdata[cbs_pkg::TEMP_BIT];
        meas_r                  <= pwdata[cbs_pkg::MEAS_LSB +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Activity state; an unexpected exit outranks a normal one
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= cbs_pkg::ACT_OFF;
    end else if (launch) begin
      act_r <= cbs_pkg::ACT_RUN;
    end else if (wr_ctrl) begin
      act_r <= cbs_pkg::ACT_OFF;
    end else if (act_r == cbs_pkg::ACT_RUN) begin
      if (exit_thermal || exit_timeout || exit_cal_fault)
        act_r <= cbs_pkg::ACT_HALT;
      else if (exit_normal)
        act_r <= cbs_pkg::ACT_DONE;
    end
  end

  // ----------------------------------------------------------------
  // Elapsed timer in mode units; saturates rather than wrapping
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_r <= '0;
      unit_r  <= '0;
    end else if (launch) begin
      timer_r <= '0;
      unit_r  <= '0;
    end else if (sec_tick && act_r == cbs_pkg::ACT_RUN) begin
      if (unit_r >= unit_secs(balance_mode) - 12'h001) begin
        unit_r <= '0;
        if (timer_r != 10'h3ff) timer_r <= timer_r + 10'h001;
      end else begin
        unit_r <= unit_r + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Progress notice in real seconds, also while the hold keeps power
  // ----------------------------------------------------------------
  logic        ntf_run; // Notice counter may advance
  logic [13:0] ntf_end; // Last second of the interval
  assign ntf_run = (run_md && act_r == cbs_pkg::ACT_RUN) || hold_active;
  assign ntf_end = 14'((cbs_pkg::SEC_PER_HOUR << ntf_r) >> 1) - 14'h0001;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ntf_cnt_r             <= '0;
      progress_notice_alert <= 1'b0;
    end else begin
      progress_notice_alert <= 1'b0;
      if (launch || ntf_r == 2'h0 || !ntf_run) begin
        ntf_cnt_r <= '0;
      end else if (sec_tick) begin
        if (ntf_cnt_r >= ntf_end) begin
          ntf_cnt_r             <= '0;
          progress_notice_alert <= 1'b1;
        end else begin
          ntf_cnt_r <= ntf_cnt_r + 14'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Supervisory measurements and threshold check
  // ----------------------------------------------------------------
  assign sup.pair_done = pair_done && run_md && act_r == cbs_pkg::ACT_RUN;
  assign sup.meas_en   = meas_r[1];
  assign sup.cal_rate  = cal_r;
  assign sup.restart   = launch;
  assign adc_request   = sup.adc_req;
  assign cal_request   = sup.cal_req;

  // Checking only with measure+check; the result is trusted as unipolar
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) uv_suspend <= 1'b0;
    else if (launch) uv_suspend <= 1'b0;
    else if (sup_result_valid && meas_r == cbs_pkg::MEAS_CHECK && sup_result < thr_r)
      uv_suspend <= 1'b1;
  end

  cbs_sec_div #(.CYCLES(CYC_PER_SEC)) u_div (.clk(clk), .rst_n(rst_n), .sec_tick(sec_tick));
  cbs_sup_sched u_sched (.clk(clk), .rst_n(rst_n), .sup(sup.sched));

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  uv_user_a: assert property (wr_uv && !auto_md && !pwdata[0]
    |=> thr_r == $past(pwdata[15:2])) else $error("user threshold not loaded");
  uv_cell_a: assert property (wr_uv && !auto_md && pwdata[0] && !scan_active
    && !extreme_search_polarity |=> thr_r == $past(picked)) else $error("cell not loaded");
  uv_pol_a: assert property (wr_uv && !auto_md && pwdata[0] && !scan_active
    && extreme_search_polarity |=> thr_r == 14'h3fff) else $error("polarity force failed");
  uv_reject_a: assert property (reject |=> write_rejected_alert && $stable(thr_r)
    ##1 !write_rejected_alert) else $error("reject wrong");
  dly_block_a: assert property (wr_dly && run_md |=> $stable(ntf_r) && $stable(cal_r))
    else $error("delay write not blocked");
  launch_run_a: assert property (launch |=> timer_r == 10'h0 && act_r == 2'h1
    && launch_pulse) else $error("launch wrong");
  act_halt_a: assert property (act_r == 2'h1 && !wr_ctrl && exit_thermal
    |=> act_r == 2'h3) else $error("halt not reported");
  act_done_a: assert property (act_r == 2'h1 && !wr_ctrl && exit_normal && !exit_thermal
    && !exit_timeout && !exit_cal_fault |=> act_r == 2'h2) else $error("done not reported");
  notice_off_a: assert property (ntf_r == 2'h0 |=> !progress_notice_alert)
    else $error("notice while disabled");
  meas_off_a: assert property (!meas_r[1] && !wr_ctrl |=> ##1 !adc_request && !cal_request)
    else $error("request with measurements off");

  launch_c: cover property (launch ##[1:20] exit_normal);
  reject_c: cover property (reject);
  cal_c: cover property (cal_request);
endmodule : cbs_ctrl
`default_nettype wire

// ---- verification/test_cell_balance_sequencer_control.sv ----
// Self-checking bench for the cell-balance sequencer control block
`timescale 1ns/1ns
`default_nettype none
module test_cell_balance_sequencer_control;
  logic         clk, rst_n, psel, penable, pwrite, pready, pslverr, rej, wra;
  logic         calr, adcr, pol, scan, pd, sv, hld, uvs, lp, ntf;
  logic [11:0]  paddr, fo;
  logic [13:0]  sr;
  logic [31:0]  pwdata, prdata;
  logic [195:0] cv;
  logic [3:0]   low, ex;
  int           err_count, checked, cyc, ncal, nadc, nl, nntf, thr, ev, dly, f, cd, nc;
  int           per[8] = '{0, 2, 4, 8, 12, 0, 24, 32}; // Pairs per calibration, 0 never
  cbs_ctrl #(.CYC_PER_SEC(2)) dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cell_voltage_result(cv), .lowest_cell_index(low),
    .extreme_search_polarity(pol), .scan_active(scan), .pair_done(pd), .sup_result_valid(sv),
    .sup_result(sr), .hold_active(hld), .exit_normal(ex[0]), .exit_thermal(ex[1]),
    .exit_timeout(ex[2]), .exit_cal_fault(ex[3]), .balance_mode(fo[11:9]), .launch_pulse(lp),
    .adc_request(adcr), .cal_request(calr), .uv_suspend(uvs), .progress_notice_alert(ntf),
    .write_rejected_alert(wra), .filter_restart_request(fo[8]), .shutdown_hold_select(fo[7:6]),
    .balance_duty_cycle(fo[5:2]), .completion_alert_enable(fo[1]), .thermal_exit_enable(fo[0]));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Counts output pulses; a hang ends the run as a mismatch
  always @(posedge clk) begin
    ncal += int'(calr === 1'b1);
    nadc += int'(adcr === 1'b1);
    nl   += int'(lp === 1'b1);
    nntf += int'(ntf === 1'b1);
    if (++cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    err_count += int'(s !== e);
    if (s !== e) $display("wrong value at %0t ns: seen %h expected %h", $time, s, e);
  endtask : chk
  task automatic wrap_up;
    $display("%0d compared, %0d wrong", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // A read is compared with pslverr folded into bit 31, since upper bits read zero
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, e = 32'h0);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!w) chk({pslverr, prdata[30:0]}, e);
    {psel, penable} <= 2'b00;
    @(posedge clk) rej = wra;
  endtask : apb
  initial begin
    {psel, penable, pwrite, pol, scan, pd, sv, hld, ex, paddr, pwdata, low, cv, sr, rst_n} = '0;
    void'($urandom(34));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h1f8, 32'h0, 32'h0000fffc);
    apb(1'b0, 12'h3f0, 32'h0, 32'h80000000);
    for (int i = 0; i < 6; i++) begin
      thr = int'($urandom_range(16383));
      {pol, low, cv} <= {i[1], 4'($urandom_range(13)), 196'({7{$urandom}})};
      apb(1'b1, 12'h1f8, 32'(thr * 4 + i % 2));
      ev = (i % 2 == 0) ? thr : (i[1] ? 16383 : int'(cv[low * 14 +: 14]));
      apb(1'b0, 12'h1f8, 32'h0, 32'(ev * 4 + i % 2));
    end
    scan <= 1'b1;
    apb(1'b1, 12'h1f8, 32'h1);
    chk(32'(rej), 32'h1);
    // Walk every mode downwards so the bench ends with delay writes open
    for (int k = 7; k >= 0; k--) begin
      f = int'($urandom & 32'h7fc);
      apb(1'b1, 12'h200, 32'(k * 2048 + f));
      chk(32'(fo), 32'(k * 2048 + f) >> 2);
      apb(1'b1, 12'h1fc, 32'hfff8 + 32'(k));
      dly = (k == 1 || k > 3) ? dly : 32'h300 + k;
      apb(1'b0, 12'h1fc, 32'h0, 32'(dly));
      apb(1'b0, 12'h200, 32'h0, 32'(k * 2048 + f + (k > 0 ? 32'h4000 : 0)));
      ex <= 4'(1 << k % 4);
      @(posedge clk) ex <= 4'h0;
      apb(1'b0, 12'h200, 32'h0, 32'(k * 2048 + f + (k % 4 ? 32'hc000 : k ? 32'h8000 : 0)));
    end
    chk(32'(nl), 32'h7);
    $display("test registers done");
    apb(1'b1, 12'h1f8, 32'h8000);
    // Codes 7, 0..6 with measurements on, then code 7 again with them off
    for (int c = 0; c < 9; c++) begin
      cd = (c + 7) % 8;
      apb(1'b1, 12'h200, 32'h0);
      apb(1'b1, 12'h1fc, 32'h100 + 32'(cd));
      apb(1'b1, 12'h200, (c < 8) ? 32'h0802 : 32'h0800);
      repeat (64) @(posedge clk) pd <= ~pd;
      repeat (2) @(posedge clk);
      nc = (c < 8 && per[cd] > 0) ? 32 / per[cd] : 0;
      chk(32'(ncal * 256 + nadc), 32'((c < 8) ? nc * 256 + 32 - nc : 0));
      ncal = 0;
      nadc = 0;
    end
    $display("test supervision done");
    hld <= 1'b1;
    apb(1'b1, 12'h200, 32'h0803);
    {sv, sr} <= {1'b1, 14'h2000};
    @(posedge clk) sv <= 1'b0;
    apb(1'b0, 12'h220, 32'h0, 32'h4000);
    {sv, sr} <= {1'b1, 14'h1fff};
    @(posedge clk) sv <= 1'b0;
    apb(1'b0, 12'h220, 32'h0, 32'h6000);
    chk(32'(uvs), 32'h1);
    repeat (7300) @(posedge clk);
    apb(1'b1, 12'h200, 32'h0);
    repeat (7300) @(posedge clk);
    chk(32'(nntf), 32'h2);
    $display("test notice done");
    wrap_up();
  end
endmodule : test_cell_balance_sequencer_control
`default_nettype wire
